// [intr_timer_ctrl_xfer_decode.sv]
// Decoder and executor for the pin-level skip tests and the nibble
// transfers between the working register and the control register bank.
// Assumes the core presents one instruction per cycle with a valid strobe,
// and loads the working register from o_acc_data when o_acc_load is high.
//
// The address map and the strobed register port are this design's own decisions.
`timescale 1ns/10ps
`include "xfer_decode_defines.svh"

// Overview of operation
// RULE_01: Pin0 test, polarity one: skip when high
// RULE_02: Pin0 test, polarity zero: skip when low
// RULE_03: Pin1 test, polarity one: skip when high
// RULE_04: Pin1 test, polarity zero: skip when low
// RULE_05: Read first enable register into working register
// RULE_06: Write working register to first enable
// RULE_07: Read second enable register into working register
// RULE_08: Write working register to second enable
// RULE_09: Read first external control into working register
// RULE_10: Write working register to first external control
// RULE_11: Read second external control into working register
// RULE_12: Write working register to second external control
// RULE_13: Read first timer control into working register
// RULE_14: Write working register to first timer control
// RULE_15: Read second timer control into working register
// RULE_16: Write working register to second timer control
// RULE_17: Read third timer control into working register
// RULE_18: Write working register to third timer control
// RULE_19: Fourth timer control read and write transfers
// RULE_20: Sixth timer control read and write transfers
// RULE_21: Skipped instruction changes nothing, counter still advances
module intr_timer_ctrl_xfer_decode #(
    parameter int NIB_WIDTH = `NIB_W
) (
    // Clock and reset
    input wire logic i_clk_sys,
    input wire logic i_rst,
    // Instruction issue from the core
    input wire logic i_instr_valid,
    input wire logic [`OP_W-1:0] i_instr,
    input wire xfer_decode_pkg::nib_type i_acc,
    // External interrupt pins
    input wire logic i_ext_irq_pin_zero,
    input wire logic i_ext_irq_pin_one,
    // Register port
    input wire logic [`IDX_W-1:0] i_addr,
    input wire xfer_decode_pkg::nib_type i_wdata,
    input wire logic i_wr,
    input wire logic i_rd,
    output logic [`NIB_W-1:0] o_rdata,
    // Working register load
    output logic o_acc_load,
    output logic [`NIB_W-1:0] o_acc_data,
    // Skip handling
    output logic o_skip_taken,
    output logic o_skip_pending,
    output logic o_squashed,
    // Control register bank contents
    output logic [`NIB_W-1:0] o_ext_irq_ctl_first,
    output logic [`NIB_W-1:0] o_ext_irq_ctl_second,
    output logic [`NIB_W-1:0] o_irq_enable_ctl_first,
    output logic [`NIB_W-1:0] o_irq_enable_ctl_second,
    output logic [`NIB_W-1:0] o_tmr_ctl_first,
    output logic [`NIB_W-1:0] o_tmr_ctl_second,
    output logic [`NIB_W-1:0] o_tmr_ctl_third,
    output logic [`NIB_W-1:0] o_tmr_ctl_fourth,
    output logic [`NIB_W-1:0] o_tmr_ctl_sixth
);
    import xfer_decode_pkg::*;

    // The struct and the bank are laid out for nibble registers only
    if (NIB_WIDTH != `NIB_W) begin : g_width_check
        $error("NIB_WIDTH must equal the nibble width");
    end

    // Returns {hit, index} for a read-to-working-register opcode
    function automatic logic [`IDX_W:0] rd_decode(input logic [`OP_W-1:0] op);
        logic [`IDX_W:0] r;
        r = '0;
        unique case (op)
            `OP_RD_IRQ_EN1: r = {1'b1, `IDX_IRQ_EN1};
            `OP_RD_IRQ_EN2: r = {1'b1, `IDX_IRQ_EN2};
            `OP_RD_EXT_CTL1: r = {1'b1, `IDX_EXT_CTL1};
            `OP_RD_EXT_CTL2: r = {1'b1, `IDX_EXT_CTL2};
            `OP_RD_TMR1: r = {1'b1, `IDX_TMR1};
            `OP_RD_TMR2: r = {1'b1, `IDX_TMR2};
            `OP_RD_TMR3: r = {1'b1, `IDX_TMR3};
            `OP_RD_TMR4: r = {1'b1, `IDX_TMR4};
            `OP_RD_TMR6: r = {1'b1, `IDX_TMR6};
            default: r = '0;
        endcase
        return r;
    endfunction

    // Returns {hit, index} for a write-from-working-register opcode
    function automatic logic [`IDX_W:0] wr_decode(input logic [`OP_W-1:0] op);
        logic [`IDX_W:0] r;
        r = '0;
        unique case (op)
            `OP_WR_IRQ_EN1: r = {1'b1, `IDX_IRQ_EN1};
            `OP_WR_IRQ_EN2: r = {1'b1, `IDX_IRQ_EN2};
            `OP_WR_EXT_CTL1: r = {1'b1, `IDX_EXT_CTL1};
            `OP_WR_EXT_CTL2: r = {1'b1, `IDX_EXT_CTL2};
            `OP_WR_TMR1: r = {1'b1, `IDX_TMR1};
            `OP_WR_TMR2: r = {1'b1, `IDX_TMR2};
            `OP_WR_TMR3: r = {1'b1, `IDX_TMR3};
            `OP_WR_TMR4: r = {1'b1, `IDX_TMR4};
            `OP_WR_TMR6: r = {1'b1, `IDX_TMR6};
            default: r = '0;
        endcase
        return r;
    endfunction

    decode_state_type st_r;
    decode_state_type st_nxt;
    logic exec;
    logic [`IDX_W:0] rd_hit;
    logic [`IDX_W:0] wr_hit;
    nib_type status;

    skip_test_if tst ();

    skip_eval u_skip_eval (
        .tst(tst.eval)
    );

    // An instruction runs only when no skip is pending against it
    assign exec = i_instr_valid && !st_r.skip_pend; // RULE_21
    assign rd_hit = rd_decode(i_instr);
    assign wr_hit = wr_decode(i_instr);

    // Polarity comes from the registered bank, so a port write to the same
    // register in the test's cycle only affects the next test
    assign tst.pol0 = st_r.ctl[`IDX_EXT_CTL1][`POL_BIT];
    assign tst.pol1 = st_r.ctl[`IDX_EXT_CTL2][`POL_BIT];
    assign tst.pin0 = i_ext_irq_pin_zero;
    assign tst.pin1 = i_ext_irq_pin_one;

    always_comb begin
        if (exec && i_instr == `OP_SKIP_PIN0) begin
            tst.sel = TEST_PIN0; // RULE_01 RULE_02
        end else if (exec && i_instr == `OP_SKIP_PIN1) begin
            tst.sel = TEST_PIN1; // RULE_03 RULE_04
        end else begin
            tst.sel = TEST_NONE;
        end
    end

    always_comb begin
        status = `NIB_ZERO;
        status[`STAT_SKIP_BIT] = st_r.skip_pend;
        status[`STAT_SQUASH_BIT] = st_r.squashed;
    end

    always_comb begin
        st_nxt = st_r;
        st_nxt.acc_load = 1'b0;
        st_nxt.skip_taken = 1'b0;
        st_nxt.squashed = 1'b0;
        st_nxt.rdata = `NIB_ZERO;
        // Port read data stand only in the cycle after the strobe
        if (i_rd) begin
            if (i_addr < `IDX_W'(`NUM_CTL)) begin
                st_nxt.rdata = st_r.ctl[i_addr];
            end else if (i_addr == `ADDR_STATUS) begin
                st_nxt.rdata = status;
            end
        end
        // Port writes first, so an instruction write in the same cycle wins
        if (i_wr && i_addr < `IDX_W'(`NUM_CTL)) begin
            st_nxt.ctl[i_addr] = i_wdata;
        end
        if (i_instr_valid && st_r.skip_pend) begin
            // Skipped word: consumed, no transfer, no new skip
            st_nxt.skip_pend = 1'b0; // RULE_21
            st_nxt.squashed = 1'b1; // RULE_21
        end else if (exec) begin
            if (rd_hit[`IDX_W]) begin
                st_nxt.acc_load = 1'b1; // RULE_05 RULE_07 RULE_09 RULE_11
                st_nxt.acc_data = st_r.ctl[rd_hit[`IDX_W-1:0]]; // RULE_13 RULE_15 RULE_17
            end // RULE_19 RULE_20
            if (wr_hit[`IDX_W]) begin
                st_nxt.ctl[wr_hit[`IDX_W-1:0]] = i_acc; // RULE_06 RULE_08 RULE_10 RULE_12
            end // RULE_14 RULE_16 RULE_18 RULE_19 RULE_20
            if (tst.match) begin
                st_nxt.skip_pend = 1'b1; // RULE_01 RULE_02 RULE_03 RULE_04
                st_nxt.skip_taken = 1'b1;
            end
        end
    end

    always_ff @(posedge i_clk_sys) begin
        if (i_rst) begin
            st_r <= '0;
            st_r.ctl <= {`NUM_CTL{`CTL_RST}};
        end else begin
            st_r <= st_nxt;
        end
    end

    assign o_rdata = st_r.rdata;
    assign o_acc_load = st_r.acc_load;
    assign o_acc_data = st_r.acc_data;
    assign o_skip_taken = st_r.skip_taken;
    assign o_skip_pending = st_r.skip_pend;
    assign o_squashed = st_r.squashed;
    assign o_ext_irq_ctl_first = st_r.ctl[`IDX_EXT_CTL1];
    assign o_ext_irq_ctl_second = st_r.ctl[`IDX_EXT_CTL2];
    assign o_irq_enable_ctl_first = st_r.ctl[`IDX_IRQ_EN1];
    assign o_irq_enable_ctl_second = st_r.ctl[`IDX_IRQ_EN2];
    assign o_tmr_ctl_first = st_r.ctl[`IDX_TMR1];
    assign o_tmr_ctl_second = st_r.ctl[`IDX_TMR2];
    assign o_tmr_ctl_third = st_r.ctl[`IDX_TMR3];
    assign o_tmr_ctl_fourth = st_r.ctl[`IDX_TMR4];
    assign o_tmr_ctl_sixth = st_r.ctl[`IDX_TMR6];

    default clocking cb @(posedge i_clk_sys);
    endclocking
    default disable iff (i_rst);

    chk_pin0_high_skip: assert property ( // RULE_01
        exec && i_instr == `OP_SKIP_PIN0 && tst.pol0
        |=> o_skip_pending == $past(i_ext_irq_pin_zero) && o_skip_taken == o_skip_pending)
        else $error("pin0 high-polarity skip wrong");
    chk_pin0_low_skip: assert property ( // RULE_02
        exec && i_instr == `OP_SKIP_PIN0 && !tst.pol0
        |=> o_skip_pending == !$past(i_ext_irq_pin_zero))
        else $error("pin0 low-polarity skip wrong");
    chk_pin1_high_skip: assert property ( // RULE_03
        exec && i_instr == `OP_SKIP_PIN1 && tst.pol1
        |=> o_skip_pending == $past(i_ext_irq_pin_one))
        else $error("pin1 high-polarity skip wrong");
    chk_pin1_low_skip: assert property ( // RULE_04
        exec && i_instr == `OP_SKIP_PIN1 && !tst.pol1
        |=> o_skip_pending == !$past(i_ext_irq_pin_one))
        else $error("pin1 low-polarity skip wrong");
    chk_read_en_first: assert property ( // RULE_05
        exec && i_instr == `OP_RD_IRQ_EN1
        |=> o_acc_load && o_acc_data == $past(o_irq_enable_ctl_first))
        else $error("first enable read wrong");
    chk_write_en_first: assert property ( // RULE_06
        exec && i_instr == `OP_WR_IRQ_EN1 |=> o_irq_enable_ctl_first == $past(i_acc))
        else $error("first enable write wrong");
    chk_read_en_second: assert property ( // RULE_07
        exec && i_instr == `OP_RD_IRQ_EN2
        |=> o_acc_load && o_acc_data == $past(o_irq_enable_ctl_second))
        else $error("second enable read wrong");
    chk_write_en_second: assert property ( // RULE_08
        exec && i_instr == `OP_WR_IRQ_EN2 |=> o_irq_enable_ctl_second == $past(i_acc))
        else $error("second enable write wrong");
    chk_read_ext_first: assert property ( // RULE_09
        exec && i_instr == `OP_RD_EXT_CTL1
        |=> o_acc_load && o_acc_data == $past(o_ext_irq_ctl_first))
        else $error("first external control read wrong");
    chk_write_ext_first: assert property ( // RULE_10
        exec && i_instr == `OP_WR_EXT_CTL1 |=> o_ext_irq_ctl_first == $past(i_acc))
        else $error("first external control write wrong");
    chk_read_ext_second: assert property ( // RULE_11
        exec && i_instr == `OP_RD_EXT_CTL2
        |=> o_acc_load && o_acc_data == $past(o_ext_irq_ctl_second))
        else $error("second external control read wrong");
    chk_write_ext_second: assert property ( // RULE_12
        exec && i_instr == `OP_WR_EXT_CTL2 |=> o_ext_irq_ctl_second == $past(i_acc))
        else $error("second external control write wrong");
    chk_read_tmr_first: assert property ( // RULE_13
        exec && i_instr == `OP_RD_TMR1
        |=> o_acc_load && o_acc_data == $past(o_tmr_ctl_first))
        else $error("first timer control read wrong");
    chk_write_tmr_first: assert property ( // RULE_14
        exec && i_instr == `OP_WR_TMR1 |=> o_tmr_ctl_first == $past(i_acc))
        else $error("first timer control write wrong");
    chk_read_tmr_second: assert property ( // RULE_15
        exec && i_instr == `OP_RD_TMR2
        |=> o_acc_load && o_acc_data == $past(o_tmr_ctl_second))
        else $error("second timer control read wrong");
    chk_write_tmr_second: assert property ( // RULE_16
        exec && i_instr == `OP_WR_TMR2 |=> o_tmr_ctl_second == $past(i_acc))
        else $error("second timer control write wrong");
    chk_read_tmr_third: assert property ( // RULE_17
        exec && i_instr == `OP_RD_TMR3
        |=> o_acc_load && o_acc_data == $past(o_tmr_ctl_third))
        else $error("third timer control read wrong");
    chk_write_tmr_third: assert property ( // RULE_18
        exec && i_instr == `OP_WR_TMR3 |=> o_tmr_ctl_third == $past(i_acc))
        else $error("third timer control write wrong");
    chk_fourth_tmr_xfer: assert property ( // RULE_19
        exec && i_instr == `OP_RD_TMR4
        |=> o_acc_load && o_acc_data == $past(o_tmr_ctl_fourth))
        else $error("fourth timer control read wrong");
    chk_fourth_tmr_write: assert property ( // RULE_19
        exec && i_instr == `OP_WR_TMR4 |=> o_tmr_ctl_fourth == $past(i_acc))
        else $error("fourth timer control write wrong");
    chk_sixth_tmr_xfer: assert property ( // RULE_20
        exec && i_instr == `OP_RD_TMR6
        |=> o_acc_load && o_acc_data == $past(o_tmr_ctl_sixth))
        else $error("sixth timer control read wrong");
    chk_sixth_tmr_write: assert property ( // RULE_20
        exec && i_instr == `OP_WR_TMR6 |=> o_tmr_ctl_sixth == $past(i_acc))
        else $error("sixth timer control write wrong");
    chk_skip_squash_word: assert property ( // RULE_21
        i_instr_valid && o_skip_pending && !i_wr
        |=> o_squashed && !o_acc_load && !o_skip_pending && !o_skip_taken
            && $stable(st_r.ctl))
        else $error("skipped instruction had an effect");
    chk_skip_holds_idle: assert property ( // RULE_21
        o_skip_pending && !i_instr_valid |=> o_skip_pending)
        else $error("pending skip lost before next instruction");

    // Register port: data stand one cycle only, so a stale value is never read twice
    chk_port_read_data: assert property (
        i_rd && i_addr < `IDX_W'(`NUM_CTL) |=> o_rdata == $past(st_r.ctl[i_addr]))
        else $error("port read data wrong");
    chk_port_read_idle: assert property (
        !i_rd |=> o_rdata == `NIB_ZERO)
        else $error("port read data not cleared");
    chk_port_status_read: assert property (
        i_rd && i_addr == `ADDR_STATUS
        |=> o_rdata == {2'b00, $past(o_squashed), $past(o_skip_pending)})
        else $error("status read wrong");
    chk_port_write_lands: assert property (
        i_wr && i_addr < `IDX_W'(`NUM_CTL) && !(exec && wr_hit[`IDX_W])
        |=> st_r.ctl[$past(i_addr)] == $past(i_wdata))
        else $error("port write lost");

    // Words outside the group fall through both decoders and must leave no trace
    chk_unknown_word_quiet: assert property (
        exec && !rd_hit[`IDX_W] && !wr_hit[`IDX_W] && tst.sel == TEST_NONE && !i_wr
        |=> $stable(st_r.ctl) && !o_acc_load && !o_skip_pending)
        else $error("unknown word had an effect");

    // The skip-taken and squash flags each stand for one cycle only
    chk_taken_one_pulse: assert property ( // RULE_21
        o_skip_taken |=> !o_skip_taken)
        else $error("skip taken pulse too long");
    chk_squash_one_pulse: assert property ( // RULE_21
        o_squashed |=> !o_squashed)
        else $error("squash pulse too long");

    cov_pin0_skip: cover property (exec && i_instr == `OP_SKIP_PIN0 ##1 o_skip_taken);
    cov_pin1_skip: cover property (exec && i_instr == `OP_SKIP_PIN1 ##1 o_skip_taken);
    cov_status_read: cover property (
        i_rd && i_addr == `ADDR_STATUS && o_skip_pending ##1 o_rdata != `NIB_ZERO);
    cov_squash_write: cover property (
        o_skip_pending && i_instr_valid && i_instr == `OP_WR_TMR1 ##1 o_squashed);
    cov_write_then_read: cover property (
        exec && i_instr == `OP_WR_IRQ_EN1 ##1 exec && i_instr == `OP_RD_IRQ_EN1);
endmodule

// [xfer_decode_defines.svh]
// Constants for the control-transfer decoder: opcodes, register indices,
// field positions and reset values. Included by the package, the decoder and the bench.
`ifndef XFER_DECODE_DEFINES_SVH
`define XFER_DECODE_DEFINES_SVH

// Nibble width of the working register and of every control register, and opcode width
`define NIB_W 4
`define OP_W 10

// Pin-level skip tests
`define OP_SKIP_PIN0 10'h03a
`define OP_SKIP_PIN1 10'h03b

// Transfers between working register and control registers
`define OP_RD_IRQ_EN1 10'h054
`define OP_WR_IRQ_EN1 10'h03f
`define OP_RD_IRQ_EN2 10'h055
`define OP_WR_IRQ_EN2 10'h03e
`define OP_RD_EXT_CTL1 10'h253
`define OP_WR_EXT_CTL1 10'h217
`define OP_RD_EXT_CTL2 10'h254
`define OP_WR_EXT_CTL2 10'h218
`define OP_RD_TMR1 10'h24b
`define OP_WR_TMR1 10'h20e
`define OP_RD_TMR2 10'h24c
`define OP_WR_TMR2 10'h20f
`define OP_RD_TMR3 10'h24d
`define OP_WR_TMR3 10'h210
`define OP_RD_TMR4 10'h24e
`define OP_WR_TMR4 10'h211
`define OP_RD_TMR6 10'h250
`define OP_WR_TMR6 10'h213

// Control register bank indices, also the port addresses
`define IDX_W 4
`define IDX_EXT_CTL1 4'h0
`define IDX_EXT_CTL2 4'h1
`define IDX_IRQ_EN1 4'h2
`define IDX_IRQ_EN2 4'h3
`define IDX_TMR1 4'h4
`define IDX_TMR2 4'h5
`define IDX_TMR3 4'h6
`define IDX_TMR4 4'h7
`define IDX_TMR6 4'h8
`define NUM_CTL 9
`define ADDR_STATUS 4'h9

// Level polarity bit inside each external interrupt control register
`define POL_BIT 2

// Status register: bit 0 shows a pending skip, bit 1 a word squashed in the previous cycle
`define STAT_SKIP_BIT 0
`define STAT_SQUASH_BIT 1

// Reset values
`define CTL_RST 4'h0
`define NIB_ZERO 4'h0

`endif

// [xfer_decode_pkg.sv]
// Types shared by the control-transfer decoder and its skip evaluator.
// Assumes the defines header is on the include path.
`include "xfer_decode_defines.svh"

package xfer_decode_pkg;

    typedef enum logic [1:0] {
        TEST_NONE = 2'b00,
        TEST_PIN0 = 2'b01,
        TEST_PIN1 = 2'b10
    } skip_test_type;

    typedef logic [`NIB_W-1:0] nib_type;

    typedef struct packed {
        nib_type [`NUM_CTL-1:0] ctl;
        logic skip_pend;
        logic acc_load;
        nib_type acc_data;
        logic skip_taken;
        logic squashed;
        nib_type rdata;
    } decode_state_type;

endpackage

// [skip_test_if.sv]
// Carrier between the decoder and the pin-level skip evaluator.
// Assumes both ends run on the same core clock.
`timescale 1ns/10ps

interface skip_test_if;
    import xfer_decode_pkg::*;
    skip_test_type sel;
    logic pol0;
    logic pol1;
    logic pin0;
    logic pin1;
    logic match;

    modport dec (output sel, output pol0, output pol1, output pin0, output pin1,
                 input match);
    modport eval (input sel, input pol0, input pol1, input pin0, input pin1,
                  output match);
endinterface

// [skip_eval.sv]
// Pin-level skip evaluator: compares an interrupt pin with its polarity bit.
// Assumes pins are already synchronous to the core clock.
`timescale 1ns/10ps

module skip_eval (
    skip_test_if.eval tst
);
    import xfer_decode_pkg::*;

    always_comb begin
        unique case (tst.sel)
            TEST_NONE: begin
                tst.match = 1'b0;
            end
            // Polarity 1 skips on high, polarity 0 on low
            TEST_PIN0: begin
                tst.match = ~(tst.pin0 ^ tst.pol0); // RULE_01 RULE_02
            end
            TEST_PIN1: begin
                tst.match = ~(tst.pin1 ^ tst.pol1); // RULE_03 RULE_04
            end
            default: begin
                tst.match = 1'b0;
            end
        endcase
    end
endmodule

// [core_model.sv]
// Behavioural model of the core around the decoder: working register and counter.
// Assumes the bench requests immediate loads in step with the core clock.
`timescale 1ns/10ps

module core_model (
    // Clock and reset
    input wire logic i_clk_sys,
    input wire logic i_rst,
    // Decoder side
    input wire logic i_instr_valid,
    input wire logic i_acc_load,
    input wire logic [3:0] i_acc_data,
    // Immediate load from the bench program
    input wire logic i_set,
    input wire logic [3:0] i_set_val,
    // Core state
    output logic [3:0] o_acc,
    output logic [15:0] o_pc
);
    always_ff @(posedge i_clk_sys) begin
        if (i_rst) begin
            o_acc <= 4'h0;
            o_pc <= 16'h0;
        end else begin
            // A squashed word still moves the counter on
            if (i_instr_valid) o_pc <= o_pc + 16'h1;
            // Read results land a cycle late, so a write just after a read sees the old value
            if (i_set) o_acc <= i_set_val;
            else if (i_acc_load) o_acc <= i_acc_data;
        end
    end
endmodule

// [intr_timer_ctrl_xfer_decode_tb.sv]
// Self-checking bench: a cycle model of the decoder is compared after every clock.
// Assumes the defines header is on the include path and core_model is compiled.
`timescale 1ns/10ps
`include "xfer_decode_defines.svh"

module intr_timer_ctrl_xfer_decode_tb;
    import xfer_decode_pkg::*;
    logic i_clk_sys, i_rst, vld, wr, rd, set_en, pin0, pin1, acc_ld, taken, pend, squash;
    logic set_req, e_ld, e_tk, e_pend, e_sq;
    logic [1:0] pins;
    logic [9:0] op;
    logic [3:0] addr, wdat, set_val, set_req_val, acc, rdata, acc_dat, e_dat, e_rd, e_acc;
    logic [15:0] pc, e_pc;
    logic [3:0] bank [9];
    logic [3:0] m [9];
    logic [9:0] wop [9] = '{`OP_WR_EXT_CTL1, `OP_WR_EXT_CTL2, `OP_WR_IRQ_EN1, `OP_WR_IRQ_EN2,
        `OP_WR_TMR1, `OP_WR_TMR2, `OP_WR_TMR3, `OP_WR_TMR4, `OP_WR_TMR6};
    logic [9:0] rop [9] = '{`OP_RD_EXT_CTL1, `OP_RD_EXT_CTL2, `OP_RD_IRQ_EN1, `OP_RD_IRQ_EN2,
        `OP_RD_TMR1, `OP_RD_TMR2, `OP_RD_TMR3, `OP_RD_TMR4, `OP_RD_TMR6};
    logic [31:0] seed = 32'h5c8;
    logic [31:0] r;
    int fail_count, comparisons;

    intr_timer_ctrl_xfer_decode i_intr_timer_ctrl_xfer_decode (
        .i_clk_sys(i_clk_sys), .i_rst(i_rst), .i_instr_valid(vld), .i_instr(op), .i_acc(acc),
        .i_ext_irq_pin_zero(pin0), .i_ext_irq_pin_one(pin1), .i_addr(addr), .i_wdata(wdat),
        .i_wr(wr), .i_rd(rd), .o_rdata(rdata), .o_acc_load(acc_ld), .o_acc_data(acc_dat),
        .o_skip_taken(taken), .o_skip_pending(pend), .o_squashed(squash),
        .o_ext_irq_ctl_first(bank[0]), .o_ext_irq_ctl_second(bank[1]),
        .o_irq_enable_ctl_first(bank[2]), .o_irq_enable_ctl_second(bank[3]),
        .o_tmr_ctl_first(bank[4]), .o_tmr_ctl_second(bank[5]), .o_tmr_ctl_third(bank[6]),
        .o_tmr_ctl_fourth(bank[7]), .o_tmr_ctl_sixth(bank[8]));

    core_model i_core_model (.i_clk_sys(i_clk_sys), .i_rst(i_rst), .i_instr_valid(vld),
        .i_acc_load(acc_ld), .i_acc_data(acc_dat), .i_set(set_en), .i_set_val(set_val),
        .o_acc(acc), .o_pc(pc));

    initial begin
        i_clk_sys = 1'b0;
        forever #10 i_clk_sys = ~i_clk_sys;
    end

    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            fail_count++;
            $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic finish_test();
        $display("comparisons %0d, mismatches %0d", comparisons, fail_count);
        if (fail_count == 0 && comparisons > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask

    // Runs in the active region right after an edge, so it sees what that edge sampled
    task automatic step_model();
        logic [3:0] old [9];
        old = m;
        if (set_en) e_acc = set_val;
        else if (e_ld) e_acc = e_dat;
        e_rd = 4'h0;
        if (rd && addr < 4'h9) e_rd = old[addr];
        // Status shows the flags as they stood before this edge
        if (rd && addr == 4'h9) e_rd = {2'b00, e_sq, e_pend};
        e_ld = 1'b0;
        e_tk = 1'b0;
        e_sq = 1'b0;
        if (wr && addr < 4'h9) m[addr] = wdat;
        if (vld) e_pc = e_pc + 16'h1;
        if (vld && e_pend) begin
            e_sq = 1'b1;
            e_pend = 1'b0;
        end else if (vld) begin
            for (int k = 0; k < 9; k++) begin
                if (op == wop[k]) m[k] = acc;
                if (op == rop[k]) begin
                    e_ld = 1'b1;
                    e_dat = old[k];
                end
            end
            if ((op == `OP_SKIP_PIN0 || op == `OP_SKIP_PIN1) &&
                ((op[0] ? pin1 : pin0) == old[op[0]][`POL_BIT])) begin
                e_tk = 1'b1;
                e_pend = 1'b1;
            end
        end
    endtask

    task automatic cyc(input logic v, input logic [9:0] o, input logic w, input logic rq,
                       input logic [3:0] a, input logic [3:0] d);
        @(posedge i_clk_sys);
        step_model();
        vld <= v;
        op <= o;
        wr <= w;
        rd <= rq;
        addr <= a;
        wdat <= d;
        set_en <= set_req;
        set_val <= set_req_val;
        pin0 <= pins[0];
        pin1 <= pins[1];
        set_req = 1'b0;
        @(negedge i_clk_sys);
        for (int k = 0; k < 9; k++) begin
            check(bank[k], m[k]);
        end
        check(acc_ld, e_ld);
        if (e_ld) check(acc_dat, e_dat);
        check(taken, e_tk);
        check(pend, e_pend);
        check(squash, e_sq);
        check(rdata, e_rd);
        check(acc, e_acc);
        check(pc, e_pc);
    endtask

    task automatic ins(input logic [9:0] o);
        cyc(1'b1, o, 1'b0, 1'b0, 4'h0, 4'h0);
    endtask

    task automatic idle();
        cyc(1'b0, 10'h000, 1'b0, 1'b0, 4'h0, 4'h0);
    endtask

    task automatic load_acc(input logic [3:0] v);
        set_req = 1'b1;
        set_req_val = v;
        idle();
    endtask

    initial begin
        repeat (1500) @(posedge i_clk_sys);
        fail_count++;
        finish_test();
    end

    initial begin
        {i_rst, vld, wr, rd, set_en, pin0, pin1, set_req} = 8'hff & 8'h80;
        {op, addr, wdat, set_val, set_req_val, pins} = '0;
        {e_ld, e_tk, e_pend, e_sq, e_dat, e_rd, e_acc, e_pc} = '0;
        m = '{default: 4'h0};
        fail_count = 0;
        comparisons = 0;
        repeat (4) @(posedge i_clk_sys);
        i_rst <= 1'b0;
        idle();
        $display("test reset done");
        for (int k = 0; k < 9; k++) begin
            load_acc(rnd());
            ins(wop[k]);
            ins(rop[k]);
            idle();
            idle();
        end
        $display("test transfers done");
        for (int k = 0; k < 16; k++) begin
            cyc(1'b0, 10'h000, 1'b1, 1'b0, k[3:0], rnd());
            cyc(1'b0, 10'h000, 1'b0, 1'b1, k[3:0], 4'h0);
            idle();
        end
        $display("test register port done");
        // Every pin, polarity and level, then a write that must vanish when skipped
        for (int t = 0; t < 8; t++) begin
            r = rnd();
            cyc(1'b0, 10'h000, 1'b1, 1'b0, {3'h0, t[2]}, {r[3], t[1], r[1:0]});
            pins = {t[0], t[0]};
            load_acc(r[7:4]);
            ins(t[2] ? `OP_SKIP_PIN1 : `OP_SKIP_PIN0);
            // The status read beside the skipped word sees the pending bit,
            // the next one sees the squash bit
            cyc(1'b1, wop[8], 1'b0, 1'b1, `ADDR_STATUS, 4'h0);
            cyc(1'b0, 10'h000, 1'b0, 1'b1, `ADDR_STATUS, 4'h0);
        end
        $display("test pin skips done");
        for (int t = 0; t < 300; t++) begin
            r = rnd();
            pins = r[1:0];
            set_req = r[2] & r[3];
            set_req_val = r[7:4];
            if (r[12:8] < 5'd9) cyc(r[13] | r[14], wop[r[11:8]], 1'b0, 1'b0, 4'h0, 4'h0);
            else if (r[12:8] < 5'd18) cyc(1'b1, rop[r[12:8] - 5'd9], 1'b0, 1'b0, 4'h0, 4'h0);
            else if (r[12:8] < 5'd30) ins(r[15] ? `OP_SKIP_PIN1 : `OP_SKIP_PIN0);
            else ins(10'h3ff);
        end
        $display("test random stream done");
        finish_test();
    end
endmodule
